// ### common/sls_pkg.sv
package sls_pkg;

    // Clock rates in hertz
    localparam int SLS_CLOCK_HZ        = 25_000_000;
    localparam int SLS_STATUS_CLOCK_HZ = 12_500_000;
    // System clocks per status clock half period
    localparam int SLS_HALF_CLOCKS     = SLS_CLOCK_HZ / (2 * SLS_STATUS_CLOCK_HZ);

    // Frame geometry
    localparam int SLS_STATUS_BITS  = 8;
    localparam int SLS_FAST_PORTS   = 24;
    localparam int SLS_GIGA_PORTS   = 2;
    localparam int SLS_PORTS        = SLS_FAST_PORTS + SLS_GIGA_PORTS;
    localparam int SLS_SLOT_EXTRA_A = 26;
    localparam int SLS_SLOT_EXTRA_B = 27;
    localparam int SLS_SLOTS_USED   = 28;
    localparam int SLS_SLOT_AW      = 5;
    localparam int SLS_CYCLE_W      = 8;
    localparam logic [7:0] SLS_PAD_START  = 8'hE0;
    localparam logic [7:0] SLS_SYNC_CYCLE = 8'hFF;
    localparam logic [7:0] SLS_IDLE_CYCLE = 8'hFE;

    // Indicator bit positions within a port byte
    localparam int SLS_BIT_FLOW     = 0;
    localparam int SLS_BIT_TX       = 1;
    localparam int SLS_BIT_RX       = 2;
    localparam int SLS_BIT_ACTIVITY = 3;
    localparam int SLS_BIT_LINK     = 4;
    localparam int SLS_BIT_SPEED    = 5;
    localparam int SLS_BIT_DUPLEX   = 6;
    localparam int SLS_BIT_COLL     = 7;

    // Base value of every packed slot byte
    localparam logic [7:0] SLS_BYTE_RESET = 8'h00;

    // Live status of one port, activity derived later
    typedef struct packed {
        logic collision;
        logic full_duplex;
        logic speed_100;
        logic link_up;
        logic receiving;
        logic transmitting;
        logic flow_control;
    } sls_port_t;

    // System status carried in the two extra bytes
    typedef struct packed {
        logic bist_done;
        logic bist_in_process;
        logic ram_error;
        logic bist_fail;
        logic link_init_complete;
        logic checksum_ok;
        logic init_start;
        logic init_done;
        logic gigabit_port_b_speed;
        logic gigabit_port_a_speed;
    } sls_sys_t;

endpackage

// ### design/sls_status_ram.sv
`timescale 1ns/1ps
// Small snapshot store of slot bytes, registered read
module sls_status_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    // Storage array, contents need no reset
    logic [WIDTH-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port, one clock of latency
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ### design/sls_bit_timer.sv
`timescale 1ns/1ps
// Divider making the status clock from the system clock
module sls_bit_timer #(
    parameter int HALF = 1
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic enable,
    output logic      status_clock,
    output logic      fall_tick
);

    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

    // Clocks spent in the current half period
    logic [CW-1:0] half_cnt;
    logic          half_done;

    assign half_done = (half_cnt == CW'(HALF - 1));
    // Pulse on the edge where the status clock falls
    assign fall_tick = enable && status_clock && half_done;

    // Half period counter, parked while disabled
    always_ff @(posedge clock)
    begin
        if (!rst_n || !enable || half_done)
        begin
            half_cnt <= '0;
        end
        else
        begin
            half_cnt <= half_cnt + CW'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || !enable)
        begin
            status_clock <= 1'b0;
        end
        else if (half_done)
        begin
            status_clock <= !status_clock;
        end
    end

    property p_clock_toggle;
        @(posedge clock) disable iff (!rst_n)
        (enable && $past(enable) && half_done) |=> (status_clock != $past(status_clock));
    endproperty
    a_clock_toggle: assert property (p_clock_toggle)
        else $error("status clock did not toggle");

endmodule

// ### design/sls_led_stream.sv
`timescale 1ns/1ps
// Serial status stream toward the external LED decoder
module sls_led_stream
    import sls_pkg::*;
#(
    parameter int HALF_CLOCKS = SLS_HALF_CLOCKS
) (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic                              parallel_mode,
    input  wire sls_port_t [SLS_PORTS-1:0]         port_status,
    input  wire sls_sys_t                          sys_status,
    output logic                                   status_serial_clock,
    output logic                                   status_frame_sync,
    output logic                                   status_serial_out,
    output logic [SLS_GIGA_PORTS-1:0][7:0]         gigabit_led
);

    // Status clock fall pulse from the divider
    logic                   tick;
    // Frame cycle shown on the data line now
    logic [SLS_CYCLE_W-1:0] cycle;
    // Cycle that the next tick will present
    logic [SLS_CYCLE_W-1:0] next_cycle;
    // Snapshot write sweep pointer
    logic [SLS_SLOT_AW-1:0] scan_slot;
    // Byte written at the sweep pointer
    logic [7:0]             scan_byte;
    // Byte of the slot about to be shifted
    logic [7:0]             slot_byte;
    // Next cycle falls in the zero padding
    logic                   next_pad;
    // Serial stream active
    logic                   serial_on;

    assign serial_on  = !parallel_mode;
    assign next_cycle = cycle + SLS_CYCLE_W'(1);

    // Pack one port into its indicator byte
    // eight indicators per port
    function automatic logic [7:0] pack_port(input sls_port_t p);
        logic [7:0] b;
        b = SLS_BYTE_RESET;
        b[SLS_BIT_FLOW]     = p.flow_control;
        b[SLS_BIT_TX]       = p.transmitting;
        b[SLS_BIT_RX]       = p.receiving;
        b[SLS_BIT_ACTIVITY] = p.transmitting | p.receiving;
        b[SLS_BIT_LINK]     = p.link_up;
        b[SLS_BIT_SPEED]    = p.speed_100;
        b[SLS_BIT_DUPLEX]   = p.full_duplex;
        b[SLS_BIT_COLL]     = p.collision;
        return b;
    endfunction

    // First extra status byte
    function automatic logic [7:0] pack_extra_a(input sls_sys_t s);
        logic [7:0] b;
        b = SLS_BYTE_RESET;
        b[0] = s.gigabit_port_a_speed;
        b[1] = s.gigabit_port_b_speed;
        b[2] = s.init_done;
        b[3] = s.init_start;
        b[4] = s.checksum_ok;
        b[5] = s.link_init_complete;
        b[6] = s.bist_fail;
        b[7] = s.ram_error;
        return b;
    endfunction

    // Second extra status byte, upper bits zero
    function automatic logic [7:0] pack_extra_b(input sls_sys_t s);
        logic [7:0] b;
        b = SLS_BYTE_RESET;
        b[0] = s.bist_in_process;
        b[1] = s.bist_done;
        return b;
    endfunction

    // Divider for the status clock
    sls_bit_timer #(
        .HALF (HALF_CLOCKS)
    ) u_timer (
        .clock        (clock),
        .rst_n        (rst_n),
        .enable       (serial_on),
        .status_clock (status_serial_clock),
        .fall_tick    (tick)
    );

    // Byte for the slot under the sweep pointer
    always_comb
    begin
        scan_byte = SLS_BYTE_RESET;
        if (scan_slot < SLS_SLOT_AW'(SLS_PORTS))
        begin
            scan_byte = pack_port(port_status[scan_slot]);
        end
        // extra bytes in slots 26, 27
        else if (scan_slot == SLS_SLOT_AW'(SLS_SLOT_EXTRA_A))
        begin
            scan_byte = pack_extra_a(sys_status);
        end
        else if (scan_slot == SLS_SLOT_AW'(SLS_SLOT_EXTRA_B))
        begin
            scan_byte = pack_extra_b(sys_status);
        end
    end

    // Sweep pointer over the used slots
    // Refreshing one slot per clock keeps each byte
    // at most 28 clocks old, at tiny cost
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            scan_slot <= '0;
        end
        else if (scan_slot == SLS_SLOT_AW'(SLS_SLOTS_USED - 1))
        begin
            scan_slot <= '0;
        end
        else
        begin
            scan_slot <= scan_slot + SLS_SLOT_AW'(1);
        end
    end

    // Slot store; read address looks one cycle ahead
    // slot index is cycle divided by eight
    sls_status_ram #(
        .WIDTH (8),
        .DEPTH (32),
        .AW    (SLS_SLOT_AW)
    ) u_ram (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (1'b1),
        .wr_addr (scan_slot),
        .wr_data (scan_byte),
        .rd_addr (next_cycle[7:3]),
        .rd_data (slot_byte)
    );

    assign next_pad = (next_cycle >= SLS_PAD_START);

    // Frame cycle counter, wraps every 256 cycles
    // 256 status cycles per frame
    always_ff @(posedge clock)
    begin
        if (!rst_n || parallel_mode)
        begin
            // Parked so the first serial cycle is sync
            cycle <= SLS_IDLE_CYCLE;
        end
        else if (tick)
        begin
            cycle <= next_cycle;
        end
    end

    // Serial data, changed only on the clock fall
    // one bit per status clock cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n || parallel_mode)
        begin
            status_serial_out <= 1'b0;
        end
        else if (tick)
        begin
            // stream never pauses in serial mode
            if (next_pad)
            begin
                status_serial_out <= 1'b0;
            end
            else
            begin
                status_serial_out <= slot_byte[next_cycle[2:0]];
            end
        end
    end

    // Sync during the last padding cycle
    // one cycle, right before port 0 bit 0
    always_ff @(posedge clock)
    begin
        if (!rst_n || parallel_mode)
        begin
            status_frame_sync <= 1'b0;
        end
        else if (tick)
        begin
            status_frame_sync <= (next_cycle == SLS_SYNC_CYCLE);
        end
    end

    // Parallel gigabit indicators, zero in serial mode
    // only gigabit ports without the stream
    always_ff @(posedge clock)
    begin
        if (!rst_n || !parallel_mode)
        begin
            gigabit_led <= '0;
        end
        else
        begin
            gigabit_led[0] <= pack_port(port_status[SLS_FAST_PORTS]);
            gigabit_led[1] <= pack_port(port_status[SLS_FAST_PORTS + 1]);
        end
    end

    // Helper: clocks since the last sync rise
    logic [10:0] since_sync;
    logic        sync_seen;

    always_ff @(posedge clock)
    begin
        if (!rst_n || parallel_mode)
        begin
            since_sync <= '0;
            sync_seen  <= 1'b0;
        end
        else if ($rose(status_frame_sync))
        begin
            since_sync <= 11'h001;
            sync_seen  <= 1'b1;
        end
        else
        begin
            since_sync <= since_sync + 11'h001;
        end
    end

    // Sequences for the sync step
    sequence s_sync_start;
        tick && next_cycle == SLS_SYNC_CYCLE && serial_on;
    endsequence

    sequence s_sync_body;
        status_frame_sync [*2] ##1 !status_frame_sync;
    endsequence

    property p_sync_shape;
        @(posedge clock) disable iff (!rst_n || parallel_mode)
        s_sync_start |=> s_sync_body;
    endproperty
    a_sync_shape: assert property (p_sync_shape)
        else $error("sync pulse not one status cycle");

    property p_sync_data_zero;
        @(posedge clock) disable iff (!rst_n)
        status_frame_sync |-> !status_serial_out;
    endproperty
    a_sync_data_zero: assert property (p_sync_data_zero)
        else $error("data not zero during sync");

    property p_frame_len;
        @(posedge clock) disable iff (!rst_n || parallel_mode)
        ($rose(status_frame_sync) && sync_seen) |->
            (since_sync == 11'(256 * 2 * HALF_CLOCKS));
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length not 256 status cycles");

    property p_pad_zero;
        @(posedge clock) disable iff (!rst_n)
        (cycle >= SLS_PAD_START) |-> !status_serial_out;
    endproperty
    a_pad_zero: assert property (p_pad_zero)
        else $error("padding cycle carries data");

    property p_data_stable;
        @(posedge clock) disable iff (!rst_n || parallel_mode)
        (!$past(tick) && $past(serial_on)) |-> $stable(status_serial_out);
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data changed away from clock fall");

    property p_cycle_step;
        @(posedge clock) disable iff (!rst_n || parallel_mode)
        tick |=> (cycle == $past(next_cycle));
    endproperty
    a_cycle_step: assert property (p_cycle_step)
        else $error("frame cycle did not advance by one");

    property p_activity;
        @(posedge clock) disable iff (!rst_n)
        (scan_slot < SLS_SLOT_AW'(SLS_PORTS)) |->
            (scan_byte[SLS_BIT_ACTIVITY] == (port_status[scan_slot].transmitting
                                             | port_status[scan_slot].receiving));
    endproperty
    a_activity: assert property (p_activity)
        else $error("activity bit not tx or rx");

    property p_giga_speed;
        @(posedge clock) disable iff (!rst_n)
        (scan_slot == SLS_SLOT_AW'(SLS_SLOT_EXTRA_A)) |->
            (scan_byte[1:0] == {sys_status.gigabit_port_b_speed,
                                sys_status.gigabit_port_a_speed});
    endproperty
    a_giga_speed: assert property (p_giga_speed)
        else $error("gigabit speed bits wrong");

    // Upper bits of the second extra byte stay zero
    property p_extra_b;
        @(posedge clock) disable iff (!rst_n)
        (scan_slot == SLS_SLOT_AW'(SLS_SLOT_EXTRA_B)) |->
            (scan_byte == {6'h00, sys_status.bist_done, sys_status.bist_in_process});
    endproperty
    a_extra_b: assert property (p_extra_b)
        else $error("second extra byte wrong");

    // Led bytes lag the port status by one clock
    property p_parallel_quiet;
        @(posedge clock) disable iff (!rst_n)
        parallel_mode [*2] |->
            (!status_serial_clock && !status_frame_sync && !status_serial_out
             && (gigabit_led[0] == pack_port($past(port_status[SLS_FAST_PORTS])))
             && (gigabit_led[1] == pack_port($past(port_status[SLS_FAST_PORTS + 1]))));
    endproperty
    a_parallel_quiet: assert property (p_parallel_quiet)
        else $error("serial pins active in parallel mode");

    property p_serial_no_giga;
        @(posedge clock) disable iff (!rst_n)
        (serial_on && $past(serial_on)) |-> (gigabit_led == '0);
    endproperty
    a_serial_no_giga: assert property (p_serial_no_giga)
        else $error("parallel outputs driven in serial mode");

endmodule

// ### verification/sls_led_decoder.sv
`timescale 1ns/1ps
// Behavioural stand-in for the external LED decoder
module sls_led_decoder
    import sls_pkg::*;
(
    input  wire logic                       status_serial_clock,
    input  wire logic                       status_frame_sync,
    input  wire logic                       status_serial_out,
    output logic [SLS_SLOTS_USED-1:0][7:0]  frame_bytes,
    output logic [8:0]                      frame_len,
    output logic                            pad_zero,
    output int                              frames
);
    logic [SLS_SLOTS_USED-1:0][7:0] work;    // Bytes of the frame in progress
    logic [8:0]                     cnt;     // Cycles since the last sync
    logic                           started; // First sync seen
    logic                           pad_acc; // Pad cycles all zero so far

    // Nothing published until a first sync aligns the count
    initial
    begin
        frames  = 0;
        started = 0;
        cnt     = 9'h000;
        pad_acc = 1'b1;
        work    = '0;
    end

    always @(posedge status_serial_clock)
    begin
        if (status_frame_sync)
        begin
            // Sync cycle is itself a pad cycle
            if (status_serial_out !== 1'b0)
                pad_acc = 1'b0;
            // A partial frame after a restart is published too; bench skips it
            if (started)
            begin
                frame_len   = cnt + 9'h001;
                frame_bytes = work;
                pad_zero    = pad_acc;
                frames      = frames + 1;
            end
            started = 1'b1;
            cnt     = 9'h000;
            pad_acc = 1'b1;
        end
        else
        begin
            // Status bytes land bit 0 first; the rest must read zero
            if (cnt < 9'h0E0)
                work[cnt[7:3]][cnt[2:0]] = status_serial_out;
            else if (status_serial_out !== 1'b0)
                pad_acc = 1'b0;
            cnt = cnt + 9'h001;
        end
    end
endmodule

// ### verification/tb_sls_led_stream.sv
`timescale 1ns/1ps
// Self-checking bench for the serial LED status stream
module tb_sls_led_stream
    import sls_pkg::*;
();
    logic                              clock;               // System clock
    logic                              rst_n;               // Synchronous reset
    logic                              parallel_mode;       // Gigabit-only mode
    sls_port_t [SLS_PORTS-1:0]         port_status;         // Live port status
    sls_sys_t                          sys_status;          // System flags
    logic                              status_serial_clock; // Status clock out
    logic                              status_frame_sync;   // Frame sync out
    logic                              status_serial_out;   // Serial data out
    logic [SLS_GIGA_PORTS-1:0][7:0]    gigabit_led;         // Parallel bytes
    logic [SLS_SLOTS_USED-1:0][7:0]    dec_bytes;           // Decoded frame
    logic [8:0]                        dec_len;             // Decoded length
    logic                              dec_pad;             // Pad was zero
    int                                dec_frames;          // Frames decoded
    int                                err_total;           // Mismatches
    int                                num_checks;          // Comparisons
    int                                cycles;              // Timeout count

    sls_led_stream #(.HALF_CLOCKS(1)) DUT (
        .clock               (clock),
        .rst_n               (rst_n),
        .parallel_mode       (parallel_mode),
        .port_status         (port_status),
        .sys_status          (sys_status),
        .status_serial_clock (status_serial_clock),
        .status_frame_sync   (status_frame_sync),
        .status_serial_out   (status_serial_out),
        .gigabit_led         (gigabit_led)
    );

    sls_led_decoder dec (
        .status_serial_clock (status_serial_clock),
        .status_frame_sync   (status_frame_sync),
        .status_serial_out   (status_serial_out),
        .frame_bytes         (dec_bytes),
        .frame_len           (dec_len),
        .pad_zero            (dec_pad),
        .frames              (dec_frames)
    );

    // 25 MHz clock
    initial clock = 1'b0;
    always #20 clock = ~clock;

    // Hang guard, well above the longest expected run
    initial cycles = 0;
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 12000)
        begin
            err_total = err_total + 1;
            wrap_up();
        end
    end

    // Verdict and end of run
    task automatic wrap_up();
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected slot byte of one port, activity derived here
    function automatic logic [7:0] exp_byte(input sls_port_t p);
        return {p.collision, p.full_duplex, p.speed_100, p.link_up,
                p.transmitting | p.receiving, p.receiving, p.transmitting,
                p.flow_control};
    endfunction

    // Distinct status per port; system flags flip every bit between even and odd k
    task automatic load(input int k);
        for (int n = 0; n < SLS_PORTS; n++)
            port_status[n] = sls_port_t'(7'(n * 37 + k * 11 + 5));
        sys_status = k[0] ? sls_sys_t'(10'h15A) : sls_sys_t'(10'h2A5);
    endtask

    // Bounded wait for n more decoded frames
    task automatic wait_frames(input int n);
        int target;
        target = dec_frames + n;
        repeat (2500)
        begin
            @(negedge clock);
            if (dec_frames >= target)
                break;
        end
        check(dec_frames >= target, 1'b1);
    endtask

    // Outputs quiet while reset is held
    task automatic test_reset();
        check({status_serial_clock, status_frame_sync, status_serial_out}, 3'h0);
        check(gigabit_led, 16'h0000);
    endtask

    // Clock rate and sync width over one frame from reset release
    task automatic test_timing();
        int   syncs;
        int   rises;
        logic prev;
        syncs = 0;
        rises = 0;
        prev  = status_serial_clock;
        repeat (512)
        begin
            @(negedge clock);
            if (status_frame_sync)
                syncs = syncs + 1;
            if (status_serial_clock && !prev)
                rises = rises + 1;
            prev = status_serial_clock;
        end
        check(syncs, 2);
        check(rises, 256);
    endtask

    // Whole frame content; old snapshots flushed by waiting three frames
    task automatic test_frame(input int k);
        logic [7:0] sys_lo;
        @(negedge clock);
        load(k);
        wait_frames(3);
        // Low byte of the packed flags is extra byte A in order
        sys_lo = sys_status[7:0];
        check(dec_len, 9'h100);
        check(dec_pad, 1'b1);
        for (int n = 0; n < SLS_PORTS; n++)
            check(dec_bytes[n], exp_byte(port_status[n]));
        check(dec_bytes[SLS_SLOT_EXTRA_A], sys_lo);
        check(dec_bytes[SLS_SLOT_EXTRA_B], {6'h00, sys_status.bist_done,
              sys_status.bist_in_process});
        check(gigabit_led, 16'h0000);
    endtask

    // Gigabit-only mode: bytes on parallel outputs, stream stopped
    task automatic test_parallel();
        int act;
        act = 0;
        @(negedge clock);
        load(3);
        parallel_mode = 1'b1;
        repeat (4) @(negedge clock);
        check(gigabit_led[0], exp_byte(port_status[SLS_FAST_PORTS]));
        check(gigabit_led[1], exp_byte(port_status[SLS_FAST_PORTS + 1]));
        repeat (40)
        begin
            @(negedge clock);
            if (status_serial_clock || status_frame_sync || status_serial_out)
                act = act + 1;
        end
        check(act, 0);
        parallel_mode = 1'b0;
    endtask

    // Main sequence
    initial
    begin
        err_total     = 0;
        num_checks    = 0;
        rst_n         = 1'b0;
        parallel_mode = 1'b0;
        load(0);
        repeat (19) @(negedge clock);
        test_reset();
        @(negedge clock);
        rst_n = 1'b1;
        test_timing();
        test_frame(0);
        test_frame(1);
        test_parallel();
        // Restart after leaving gigabit-only mode
        test_frame(2);
        wrap_up();
    end
endmodule
